// *** logic/spp_sync.sv ***
// Shared constants for the serial peripheral port, plus its input synchroniser.
// Assumes a single system clock domain; every pin input enters through spp_sync.

package spp_pkg;

   // ----------------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------------
   localparam int unsigned CLK_PERIOD_NS = 5;
   localparam int unsigned SYS_PER_SCK_MIN = 4;
   localparam logic [4:0] HALF_MIN = 5'(SYS_PER_SCK_MIN / 2);

   // ----------------------------------------------------------------------
   // Byte framing
   // ----------------------------------------------------------------------
   localparam int unsigned DATA_W = 8;
   localparam logic [3:0] SAMPLE_LAST = 4'h7;
   localparam logic [3:0] EDGE_LAST = 4'hf;
   localparam logic [3:0] CNT_ZERO = 4'h0;
   localparam logic [3:0] CNT_ONE = 4'h1;
   localparam logic [4:0] DIV_ONE = 5'h01;
   localparam logic [4:0] DIV_ZERO = 5'h00;
   localparam int unsigned SYNC_W = 4;

   // ----------------------------------------------------------------------
   // Reset values
   // ----------------------------------------------------------------------
   localparam logic [7:0] DATA_RST = 8'h00;
   localparam logic [1:0] RATE_RST = 2'h0;

   typedef enum logic {
      ST_IDLE,
      ST_XFER
   } spp_state_t;

endpackage

`timescale 1ns/10ps

module spp_sync #(
   parameter int W = 4
) (
   input wire logic i_clk_sys,
   input wire logic i_rst_n,
   input wire logic [W-1:0] i_async,
   output logic [W-1:0] o_sync
);

   logic [W-1:0] meta_q;

   // ----------------------------------------------------------------------
   // Two-stage synchroniser
   // ----------------------------------------------------------------------
   // Only the second stage may read the first; it settles metastability.
   always_ff @(posedge i_clk_sys) begin
      if (!i_rst_n) begin
         meta_q <= '1;
         o_sync <= '1;
      end else begin
         meta_q <= i_async;
         o_sync <= meta_q;
      end
   end

endmodule

// *** logic/spp_serial_port.sv ***
// Serial peripheral port: master or slave byte exchange over four pins.
// Assumes control bits and data strobes come from logic on i_clk_sys.
//
// Function
// R1: Master or slave selectable; master shift clock at most a quarter of system clock.
// R2: Flags report transfer complete and write collision.
// R3: Master mode fault detection recognises two masters on the bus.
// R4: Datapath holds write buffer, shift register and read buffer.
// R5: A completed received byte moves in parallel into the read buffer.
// R6: Four lines: data in, data out, shift clock, active-low select.
// R7: Master drives out-line and samples in-line; slave does the reverse.
// R8: Shift clock pin is output as master, input as slave.
// R9: Master issues exactly eight shift clocks, exchanging one byte each way.
// R10: Slave responds only while select is low; inactive when high.
// R11: Far master selects at most one slave at a time.
// R12: Only one master may exist on the bus at once.
// R13: Automatic select output toggles between bytes without software.
// R14: Master and slave shift registers form one circular shift path.
// R15: Most significant bit first by default; least first when bit set.
// R16: Bit order changes only shift order, not register bit positions.
// R17: Master with fault detection enabled monitors select pin as input.
// R18: Slave: select input; master without detection: general I/O or auto output.
// R19: Master-select bit 1 means master, 0 means slave.
// R20: Master data write starts eight clocks; then clock stops, done flag set.
// R21: Mode fault clears master-select and enable, sets fault flag.
// R22: Data write mid-transfer sets collision flag and is discarded.

`timescale 1ns/10ps

module spp_serial_port (
   input wire logic i_clk_sys,
   input wire logic i_rst_n,
   input wire logic i_ctrl_wr,
   input wire logic i_port_enable,
   input wire logic i_master_select,
   input wire logic i_lsb_first_enable,
   input wire logic i_fault_detect_disable,
   input wire logic i_select_output_enable,
   input wire logic i_cpol,
   input wire logic i_cpha,
   input wire logic [1:0] i_rate_sel,
   input wire logic i_data_wr,
   input wire logic [7:0] i_data_wdata,
   input wire logic i_done_clr,
   input wire logic i_write_collision_flag_clr,
   input wire logic i_mode_fault_flag_clr,
   output logic o_port_enable,
   output logic o_master_select,
   output logic [7:0] o_rx_data,
   output logic o_transfer_done_flag,
   output logic o_write_collision_flag,
   output logic o_mode_fault_flag,
   output logic o_busy,
   input wire logic i_shift_clock_pin,
   output logic o_shift_clock_pin,
   output logic o_shift_clock_pin_oe_n,
   input wire logic i_mosi,
   output logic o_mosi,
   output logic o_mosi_oe_n,
   input wire logic i_miso,
   output logic o_miso,
   output logic o_miso_oe_n,
   input wire logic i_ss_n,
   output logic o_ss_n,
   output logic o_ss_oe_n,
   output logic o_ss_gpio
);

   logic [spp_pkg::SYNC_W-1:0] pins_s;
   logic sck_s;
   logic mosi_s;
   logic miso_s;
   logic ss_n_s;
   logic sck_prev_q;
   logic en_q;
   logic master_select_q;
   logic lsb_q;
   logic fault_detect_disable_q;
   logic select_output_enable_q;
   logic cpol_q;
   logic cpha_q;
   logic [1:0] rate_q;
   spp_pkg::spp_state_t state_q;
   logic [4:0] div_q;
   logic [3:0] edge_q;
   logic sck_q;
   logic [7:0] tx_q;
   logic [7:0] rx_q;
   logic [3:0] cnt_q;
   logic [7:0] wbuf_q;
   logic [7:0] rbuf_q;
   logic done_q;
   logic write_collision_flag_q;
   logic mode_fault_flag_q;
   logic is_master;
   logic is_slave;
   logic slv_sel;
   logic fault_evt;
   logic abort;
   logic [4:0] half;
   logic tick;
   logic m_end;
   logic lead;
   logic trail;
   logic samp_evt;
   logic shft_evt;
   logic byte_end;
   logic in_bit;
   logic out_bit;
   logic [7:0] rx_fill;
   logic start;
   logic wr_collide;
   logic auto_ss;

   // ----------------------------------------------------------------------
   // Pin synchronisation
   // ----------------------------------------------------------------------
   // The far master's clock and select are asynchronous, so all four pins
   // pass two flops; this limits slave clock rate to well below i_clk_sys.
   spp_sync #(
      .W(spp_pkg::SYNC_W)
   ) u_sync (
      .i_clk_sys(i_clk_sys),
      .i_rst_n(i_rst_n),
      .i_async({i_shift_clock_pin, i_mosi, i_miso, i_ss_n}),
      .o_sync(pins_s)
   );

   assign sck_s = pins_s[3];
   assign mosi_s = pins_s[2];
   assign miso_s = pins_s[1];
   assign ss_n_s = pins_s[0];

   // Edge detection reads the synchronised copy; its reset level matches the
   // synchroniser's so that no false clock edge follows reset.
   always_ff @(posedge i_clk_sys) begin
      if (!i_rst_n) begin
         sck_prev_q <= 1'b1;
      end else begin
         sck_prev_q <= sck_s;
      end
   end

   // ----------------------------------------------------------------------
   // Mode decode
   // ----------------------------------------------------------------------
   assign is_master = en_q & master_select_q; // R19
   assign is_slave = en_q & ~master_select_q; // R19
   assign slv_sel = is_slave & ~ss_n_s; // R10
   assign fault_evt = is_master & ~fault_detect_disable_q & ~ss_n_s; // R3 R17
   assign auto_ss = is_master & fault_detect_disable_q & select_output_enable_q; // R18
   // A configuration write mid-byte abandons that byte.
   assign abort = fault_evt | i_ctrl_wr;

   // ----------------------------------------------------------------------
   // Configuration bits
   // ----------------------------------------------------------------------
   // A mode fault beats a simultaneous software write so a second master
   // can never be left enabled by a racing write.
   always_ff @(posedge i_clk_sys) begin
      if (!i_rst_n) begin
         en_q <= 1'b0;
         master_select_q <= 1'b0;
         lsb_q <= 1'b0;
         fault_detect_disable_q <= 1'b0;
         select_output_enable_q <= 1'b0;
         cpol_q <= 1'b0;
         cpha_q <= 1'b0;
         rate_q <= spp_pkg::RATE_RST;
      end else if (fault_evt) begin
         en_q <= 1'b0; // R21
         master_select_q <= 1'b0; // R21
      end else if (i_ctrl_wr) begin
         en_q <= i_port_enable;
         master_select_q <= i_master_select;
         lsb_q <= i_lsb_first_enable;
         fault_detect_disable_q <= i_fault_detect_disable;
         select_output_enable_q <= i_select_output_enable;
         cpol_q <= i_cpol;
         cpha_q <= i_cpha;
         rate_q <= i_rate_sel;
      end
   end

   // ----------------------------------------------------------------------
   // Master clock generator
   // ----------------------------------------------------------------------
   // Half period is never below two system clocks, so the shift clock
   // never exceeds a quarter of i_clk_sys.
   assign half = spp_pkg::HALF_MIN << rate_q; // R1
   assign tick = (state_q == spp_pkg::ST_XFER) && (div_q == half - spp_pkg::DIV_ONE);
   assign m_end = tick && (edge_q == spp_pkg::EDGE_LAST); // R9
   assign start = is_master && (state_q == spp_pkg::ST_IDLE) && i_data_wr && !abort; // R20

   // Sixteen edges make eight clocks; the clock then rests at its idle level.
   always_ff @(posedge i_clk_sys) begin
      if (!i_rst_n) begin
         state_q <= spp_pkg::ST_IDLE;
         div_q <= spp_pkg::DIV_ZERO;
         edge_q <= spp_pkg::CNT_ZERO;
         sck_q <= 1'b0;
      end else if (abort) begin
         state_q <= spp_pkg::ST_IDLE;
         div_q <= spp_pkg::DIV_ZERO;
         edge_q <= spp_pkg::CNT_ZERO;
         sck_q <= i_ctrl_wr ? i_cpol : cpol_q;
      end else begin
         unique case (state_q)
            spp_pkg::ST_IDLE: begin
               div_q <= spp_pkg::DIV_ZERO;
               edge_q <= spp_pkg::CNT_ZERO;
               sck_q <= cpol_q;
               if (start) begin
                  state_q <= spp_pkg::ST_XFER; // R20
               end
            end
            spp_pkg::ST_XFER: begin
               if (tick) begin
                  div_q <= spp_pkg::DIV_ZERO;
                  sck_q <= ~sck_q;
                  edge_q <= edge_q + spp_pkg::CNT_ONE;
                  if (m_end) begin
                     state_q <= spp_pkg::ST_IDLE; // R9 R20
                  end
               end else begin
                  div_q <= div_q + spp_pkg::DIV_ONE;
               end
            end
         endcase
      end
   end

   // ----------------------------------------------------------------------
   // Shift events
   // ----------------------------------------------------------------------
   // Master edges come from its own divider, slave edges from the pin.
   always_comb begin
      lead = 1'b0;
      trail = 1'b0;
      if (is_master) begin
         lead = tick && !edge_q[0];
         trail = tick && edge_q[0];
      end else if (slv_sel && (sck_s != sck_prev_q)) begin
         lead = (sck_s != cpol_q);
         trail = (sck_s == cpol_q);
      end
   end

   assign samp_evt = cpha_q ? trail : lead;
   assign shft_evt = cpha_q ? lead : trail;
   assign in_bit = is_master ? miso_s : mosi_s; // R7
   assign out_bit = lsb_q ? tx_q[0] : tx_q[7]; // R15
   // Received bits land in their true weight whatever the order.
   assign rx_fill = lsb_q ? {in_bit, rx_q[7:1]} : {rx_q[6:0], in_bit}; // R15 R16
   assign byte_end = samp_evt && (cnt_q == spp_pkg::SAMPLE_LAST); // R9

   // ----------------------------------------------------------------------
   // Shift register path
   // ----------------------------------------------------------------------
   // Outgoing bits leave while incoming bits fill, so one byte swaps places
   // with the partner's. The first bit is already presented before the
   // first edge, hence no shift until one sample has been taken.
   always_ff @(posedge i_clk_sys) begin
      if (!i_rst_n) begin
         tx_q <= spp_pkg::DATA_RST;
         rx_q <= spp_pkg::DATA_RST;
         cnt_q <= spp_pkg::CNT_ZERO;
      end else if (start) begin
         tx_q <= i_data_wdata; // R4 R20
         cnt_q <= spp_pkg::CNT_ZERO;
      end else if (abort || (!is_master && !slv_sel)) begin
         tx_q <= wbuf_q; // R10
         cnt_q <= spp_pkg::CNT_ZERO;
      end else if (samp_evt) begin
         rx_q <= rx_fill; // R14
         if (byte_end) begin
            cnt_q <= spp_pkg::CNT_ZERO;
            if (!is_master) begin
               tx_q <= wbuf_q;
            end
         end else begin
            cnt_q <= cnt_q + spp_pkg::CNT_ONE;
         end
      end else if (shft_evt && (cnt_q != spp_pkg::CNT_ZERO)) begin
         tx_q <= lsb_q ? {1'b0, tx_q[7:1]} : {tx_q[6:0], 1'b0}; // R14 R15
      end
   end

   // ----------------------------------------------------------------------
   // Write and read buffers
   // ----------------------------------------------------------------------
   // Writes while a byte is on the wire are dropped, never merged.
   assign wr_collide = i_data_wr && ((state_q == spp_pkg::ST_XFER) || slv_sel); // R22

   always_ff @(posedge i_clk_sys) begin
      if (!i_rst_n) begin
         wbuf_q <= spp_pkg::DATA_RST;
      end else if (i_data_wr && !wr_collide) begin
         wbuf_q <= i_data_wdata; // R4 R22
      end
   end

   // The read buffer frees the shift register for the next byte at once.
   always_ff @(posedge i_clk_sys) begin
      if (!i_rst_n) begin
         rbuf_q <= spp_pkg::DATA_RST;
      end else if (byte_end) begin
         rbuf_q <= rx_fill; // R5
      end
   end

   // ----------------------------------------------------------------------
   // Status flags
   // ----------------------------------------------------------------------
   // Each flag's set wins over a clear in the same cycle.
   always_ff @(posedge i_clk_sys) begin
      if (!i_rst_n) begin
         done_q <= 1'b0;
         write_collision_flag_q <= 1'b0;
         mode_fault_flag_q <= 1'b0;
      end else begin
         done_q <= m_end || (is_slave && byte_end) || (done_q && !i_done_clr); // R2 R20
         write_collision_flag_q <= wr_collide || (write_collision_flag_q && !i_write_collision_flag_clr); // R2 R22
         mode_fault_flag_q <= fault_evt || (mode_fault_flag_q && !i_mode_fault_flag_clr); // R21
      end
   end

   // ----------------------------------------------------------------------
   // Pins and outputs
   // ----------------------------------------------------------------------
   assign o_shift_clock_pin = sck_q;
   assign o_shift_clock_pin_oe_n = ~is_master; // R8
   assign o_mosi = out_bit;
   assign o_mosi_oe_n = ~is_master; // R6 R7
   assign o_miso = out_bit;
   assign o_miso_oe_n = ~slv_sel; // R7 R10
   // Automatic select falls for each byte and rises when idle.
   assign o_ss_n = (state_q != spp_pkg::ST_XFER); // R13
   assign o_ss_oe_n = ~auto_ss; // R17 R18
   assign o_ss_gpio = ~en_q | (master_select_q & fault_detect_disable_q & ~select_output_enable_q); // R18
   assign o_port_enable = en_q;
   assign o_master_select = master_select_q;
   assign o_rx_data = rbuf_q;
   assign o_transfer_done_flag = done_q;
   assign o_write_collision_flag = write_collision_flag_q;
   assign o_mode_fault_flag = mode_fault_flag_q;
   assign o_busy = (state_q == spp_pkg::ST_XFER) || (slv_sel && (cnt_q != spp_pkg::CNT_ZERO));

   // ----------------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------------
   default clocking cb @(posedge i_clk_sys);
   endclocking
   default disable iff (!i_rst_n);

   sequence s_master_start;
      is_master && (state_q == spp_pkg::ST_IDLE) && i_data_wr && !abort;
   endsequence

   sequence s_first_edge;
      (state_q == spp_pkg::ST_XFER) ##1 (state_q == spp_pkg::ST_XFER) [*1];
   endsequence

   chk_start_runs: assert property (s_master_start |=> s_first_edge) // R20
      else $error("Master write did not start a transfer.");

   chk_clock_rate: assert property ((state_q == spp_pkg::ST_XFER) && !abort
      && $changed(o_shift_clock_pin) |=> $stable(o_shift_clock_pin)) // R1
      else $error("Shift clock half period below two system clocks.");

   chk_byte_len: assert property (s_master_start ##1 (rate_q == 2'h0) [*1]
      |-> ##31 (state_q == spp_pkg::ST_XFER) ##1 (state_q == spp_pkg::ST_IDLE)
      || $past(abort)) // R9
      else $error("Fastest master byte did not take sixteen edges.");

   chk_done_set: assert property (m_end |=> o_transfer_done_flag) // R2
      else $error("Done flag missing after last edge.");

   chk_write_collision_flag_set: assert property (i_data_wr && (state_q == spp_pkg::ST_XFER)
      |=> o_write_collision_flag && $stable(wbuf_q)) // R22
      else $error("Collision not flagged or write not discarded.");

   chk_fault_off: assert property (fault_evt
      |=> !o_master_select && !o_port_enable && o_mode_fault_flag) // R21
      else $error("Mode fault did not disable the port.");

   chk_rx_move: assert property (byte_end |=> o_rx_data == $past(rx_fill)) // R5
      else $error("Received byte not moved to read buffer.");

   chk_sck_idle: assert property (is_master && (state_q == spp_pkg::ST_IDLE)
      && !$past(abort) |-> o_shift_clock_pin == cpol_q) // R8
      else $error("Shift clock not at idle level between bytes.");

   chk_slave_quiet: assert property (is_slave && ss_n_s // R10
      |-> o_miso_oe_n ##1 (cnt_q == spp_pkg::CNT_ZERO))
      else $error("Deselected slave drives its data line.");

   chk_auto_select: assert property (auto_ss && (state_q == spp_pkg::ST_XFER)
      |-> !o_ss_n && !o_ss_oe_n) // R13
      else $error("Automatic select not low during transfer.");

   chk_bit_order: assert property (is_master && (state_q == spp_pkg::ST_IDLE) // R15
      && i_data_wr && !abort && !lsb_q |=> o_mosi == $past(i_data_wdata[7]))
      else $error("MSB-first order not presented.");

endmodule

// *** verification/spp_far.sv ***
// Far side of the serial port: a byte slave and a byte master on a 160 ns clock.
// Assumes the bench resolves every pin from the serial port's output enables alone.
`timescale 1ns/10ps

module spp_far (
   input wire logic i_clk_sys,
   input wire logic i_sck,
   input wire logic i_mosi,
   input wire logic i_miso,
   input wire logic i_ss_n,
   input wire logic [7:0] i_s_tx,
   output logic o_miso,
   output logic o_sck,
   output logic o_mosi,
   output logic o_ss_n
);
   // ----------------------------------------------------------------------
   // Slave side
   // ----------------------------------------------------------------------
   logic [7:0] s_sh = 8'h00;
   logic [7:0] s_rx = 8'h00;
   logic [7:0] s_edges = 8'h00;
   realtime s_t0 = 0.0;
   realtime s_per = 0.0;

   // The master side idles with its clock low and its select high.
   initial begin
      o_miso = 1'b0;
      o_sck = 1'b0;
      o_mosi = 1'b0;
      o_ss_n = 1'b1;
   end

   // Select falling presents the first bit before any clock edge.
   always @(negedge i_ss_n) begin
      s_sh = i_s_tx;
      s_edges = 8'h00;
      o_miso = i_s_tx[7];
   end

   // Leading edge captures, and the first two edges give the clock period.
   always @(posedge i_sck) begin
      if (!i_ss_n) begin
         s_rx = {s_rx[6:0], i_mosi};
         s_edges = s_edges + 8'h01;
         if (s_edges == 8'h01) s_t0 = $realtime;
         if (s_edges == 8'h02) s_per = $realtime - s_t0;
      end
   end

   // Trailing edge moves the next bit out.
   always @(negedge i_sck) begin
      if (!i_ss_n) begin
         s_sh = {s_sh[6:0], 1'b1};
         o_miso = s_sh[7];
      end
   end

   // Deselected, the line toggles so a stale bit never passes for data.
   always @(negedge i_clk_sys) begin
      if (i_ss_n) o_miso = ~o_miso;
   end

   // ----------------------------------------------------------------------
   // Master side
   // ----------------------------------------------------------------------
   task automatic pull_ss(input logic v);
      o_ss_n = v;
   endtask

   // One byte with the clock standing still outside the frame.
   task automatic m_xfer(input logic sel_n, input logic [7:0] d, output logic [7:0] q);
      #1.3;
      o_ss_n = sel_n;
      #80;
      for (int i = 7; i >= 0; i--) begin
         o_mosi = d[i];
         #80;
         o_sck = 1'b1;
         q = {q[6:0], i_miso};
         #80;
         o_sck = 1'b0;
      end
      #80;
      o_ss_n = 1'b1;
      o_mosi = ~o_mosi;
   endtask
endmodule

// *** verification/spp_serial_port_tb.sv ***
// Self-checking bench for the serial port in master and slave roles.
// Assumes spp_far stands on the pins; clock phase stays 0.
`timescale 1ns/10ps

module spp_serial_port_tb;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic ctrl_wr = 1'b0, en = 1'b0, ms = 1'b0, lsb = 1'b0, dis = 1'b0, select_output_enable = 1'b0;
   logic [1:0] rate = 2'h0;
   logic cpol = 1'b0, cpha = 1'b0;
   logic data_wr = 1'b0, done_clr = 1'b0, write_collision_flag_clr = 1'b0, mode_fault_flag_clr = 1'b0;
   logic [7:0] wdata = 8'h00;
   logic [7:0] s_tx = 8'h00;
   logic [7:0] got;
   logic [7:0] rx;
   logic q_en, q_ms, done, write_collision_flag, mode_fault_flag, busy, ss_gpio;
   logic sck_o, sck_oe_n, mosi_o, mosi_oe_n, miso_o, miso_oe_n, ss_o, ss_oe_n;
   logic p_miso, p_sck, p_mosi, p_ss_n;
   wire sck_w = !sck_oe_n ? sck_o : p_sck;
   wire mosi_w = !mosi_oe_n ? mosi_o : p_mosi;
   wire miso_w = !miso_oe_n ? miso_o : p_miso;
   wire ss_w = !ss_oe_n ? ss_o : p_ss_n;
   int fail_count = 0;
   int tests_run = 0;

   spp_serial_port spp_serial_port_i (.i_clk_sys(clk), .i_rst_n(rst_n), .i_ctrl_wr(ctrl_wr),
      .i_port_enable(en), .i_master_select(ms), .i_lsb_first_enable(lsb),
      .i_fault_detect_disable(dis), .i_select_output_enable(select_output_enable), .i_cpol(cpol),
      .i_cpha(cpha), .i_rate_sel(rate), .i_data_wr(data_wr), .i_data_wdata(wdata),
      .i_done_clr(done_clr), .i_write_collision_flag_clr(write_collision_flag_clr), .i_mode_fault_flag_clr(mode_fault_flag_clr),
      .o_port_enable(q_en), .o_master_select(q_ms), .o_rx_data(rx),
      .o_transfer_done_flag(done), .o_write_collision_flag(write_collision_flag), .o_mode_fault_flag(mode_fault_flag),
      .o_busy(busy), .i_shift_clock_pin(sck_w), .o_shift_clock_pin(sck_o),
      .o_shift_clock_pin_oe_n(sck_oe_n), .i_mosi(mosi_w), .o_mosi(mosi_o),
      .o_mosi_oe_n(mosi_oe_n), .i_miso(miso_w), .o_miso(miso_o), .o_miso_oe_n(miso_oe_n),
      .i_ss_n(ss_w), .o_ss_n(ss_o), .o_ss_oe_n(ss_oe_n), .o_ss_gpio(ss_gpio));

   spp_far spp_far_i (.i_clk_sys(clk), .i_sck(sck_w), .i_mosi(mosi_w), .i_miso(miso_w),
      .i_ss_n(ss_w), .i_s_tx(s_tx), .o_miso(p_miso), .o_sck(p_sck), .o_mosi(p_mosi),
      .o_ss_n(p_ss_n));

   // ----------------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------------
   task automatic cmp_bit(input logic e, input logic a);
      tests_run++;
      if (a !== e) begin
         fail_count++;
         $display("MISMATCH t=%0t exp=%h got=%h", $time, e, a);
      end
   endtask

   task automatic cmp_byte(input logic [7:0] e, input logic [7:0] a);
      tests_run++;
      if (a !== e) begin
         fail_count++;
         $display("MISMATCH t=%0t exp=%h got=%h", $time, e, a);
      end
   endtask

   // Waits land 1 ns past the edge so the design's updates are visible.
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   task automatic cfg(input logic e, m, l, d, s, input logic [1:0] r);
      @(posedge clk);
      en <= e;
      ms <= m;
      lsb <= l;
      dis <= d;
      select_output_enable <= s;
      rate <= r;
      ctrl_wr <= 1'b1;
      @(posedge clk);
      ctrl_wr <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] d);
      @(posedge clk);
      wdata <= d;
      data_wr <= 1'b1;
      @(posedge clk);
      data_wr <= 1'b0;
   endtask

   task automatic clr();
      @(posedge clk);
      done_clr <= 1'b1;
      write_collision_flag_clr <= 1'b1;
      mode_fault_flag_clr <= 1'b1;
      @(posedge clk);
      done_clr <= 1'b0;
      write_collision_flag_clr <= 1'b0;
      mode_fault_flag_clr <= 1'b0;
   endtask

   // Bounded wait; a hang counts as a mismatch on the done flag.
   task automatic wait_done();
      int n;
      n = 0;
      while (done !== 1'b1 && n < 4000) begin
         @(posedge clk);
         n++;
      end
      #1;
      cmp_bit(1'b1, done);
   endtask

   task automatic wrap_up();
      if (fail_count == 0 && tests_run > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask

   // ----------------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------------
   task automatic t_reset();
      cyc(1);
      cmp_bit(1'b0, done | write_collision_flag | mode_fault_flag);
      cmp_bit(1'b0, q_en);
      cmp_bit(1'b1, sck_oe_n & mosi_oe_n & miso_oe_n);
      cmp_bit(1'b1, ss_gpio);
   endtask

   // Auto-select master exchanging one byte with the far slave.
   task automatic t_master(input logic l, input logic [7:0] tx, ptx, e_rx, e_far);
      s_tx = ptx;
      cfg(1'b1, 1'b1, l, 1'b1, 1'b1, 2'h1);
      cyc(1);
      cmp_bit(1'b1, q_ms);
      cmp_bit(1'b0, sck_oe_n);
      cmp_bit(1'b0, mosi_oe_n);
      cmp_bit(1'b0, ss_oe_n | ss_gpio);
      wr(tx);
      cyc(3);
      cmp_bit(1'b1, busy);
      cmp_bit(1'b0, ss_w);
      wait_done();
      cmp_byte(e_rx, rx);
      cmp_byte(e_far, spp_far_i.s_rx);
      cyc(20);
      cmp_bit(1'b1, ss_w);
      cmp_byte(8'h08, spp_far_i.s_edges);
      clr();
      cyc(1);
      cmp_bit(1'b0, done);
   endtask

   // Fastest rate with a second write landing mid-byte.
   task automatic t_collide();
      cfg(1'b1, 1'b1, 1'b0, 1'b1, 1'b1, 2'h0);
      wr(8'h5a);
      cyc(4);
      wr(8'hff);
      cyc(1);
      cmp_bit(1'b1, write_collision_flag);
      wait_done();
      cmp_byte(8'h5a, spp_far_i.s_rx);
      cmp_byte(8'h08, spp_far_i.s_edges);
      cmp_bit(1'b1, spp_far_i.s_per == 20.0);
      clr();
      cyc(1);
      cmp_bit(1'b0, write_collision_flag);
   endtask

   // Slave answering the far master, then ignoring a frame without select.
   task automatic t_slave();
      cfg(1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 2'h0);
      wr(8'h96);
      cyc(2);
      cmp_bit(1'b0, q_ms);
      cmp_bit(1'b1, sck_oe_n);
      cmp_bit(1'b1, miso_oe_n);
      spp_far_i.m_xfer(1'b0, 8'h5a, got);
      wait_done();
      cmp_byte(8'h5a, rx);
      cmp_byte(8'h96, got);
      cyc(2);
      cmp_bit(1'b1, miso_oe_n);
      clr();
      spp_far_i.m_xfer(1'b1, 8'hff, got);
      cyc(10);
      cmp_bit(1'b0, done);
      cmp_byte(8'h5a, rx);
   endtask

   // Another master pulls select low while fault detection is on.
   task automatic t_fault();
      cfg(1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 2'h0);
      cyc(2);
      cmp_bit(1'b1, q_en & ss_oe_n);
      spp_far_i.pull_ss(1'b0);
      cyc(8);
      cmp_bit(1'b1, mode_fault_flag);
      cmp_bit(1'b0, q_ms | q_en);
      spp_far_i.pull_ss(1'b1);
      cyc(4);
      cmp_bit(1'b1, mode_fault_flag);
      clr();
      cyc(1);
      cmp_bit(1'b0, mode_fault_flag);
   endtask

   // Detection off, select output off: the pin is plain I/O and never faults.
   task automatic t_gpio();
      cfg(1'b1, 1'b1, 1'b0, 1'b1, 1'b0, 2'h0);
      cyc(1);
      cmp_bit(1'b1, ss_gpio & ss_oe_n);
      spp_far_i.pull_ss(1'b0);
      cyc(8);
      cmp_bit(1'b0, mode_fault_flag);
      cmp_bit(1'b1, q_ms);
      spp_far_i.pull_ss(1'b1);
   endtask

   // Idle-high clock: the line rests high, leads low, and rests high again.
   task automatic t_polarity();
      @(posedge clk);
      cpol <= 1'b1;
      cfg(1'b1, 1'b1, 1'b0, 1'b1, 1'b1, 2'h0);
      cyc(1);
      cmp_bit(1'b1, sck_w);
      wr(8'h0f);
      cyc(3);
      cmp_bit(1'b0, sck_w);
      wait_done();
      cmp_bit(1'b1, sck_w);
   endtask

   // ----------------------------------------------------------------------
   // Clock, main sequence and watchdog
   // ----------------------------------------------------------------------
   initial begin
      forever #2.5 clk = ~clk;
   end

   // Reset runs 20 cycles, long enough to flush the pin synchronisers.
   initial begin
      repeat (20) @(posedge clk);
      rst_n <= 1'b1;
      t_reset();
      t_master(1'b0, 8'ha5, 8'h3c, 8'h3c, 8'ha5);
      t_master(1'b1, 8'h01, 8'hc1, 8'h83, 8'h80);
      t_collide();
      t_slave();
      t_fault();
      t_gpio();
      t_polarity();
      wrap_up();
   end

   // The whole run needs well under 200 us; anything longer is a hang.
   initial begin
      #200000;
      fail_count++;
      wrap_up();
   end
endmodule
